// [hdl/fcc_ctrl.sv]
// Flash command controller: Wishbone registers, command sequencer, read path
//
// Contract
// - Command 0x0E enters identifier read mode; ready falls once readable.
// - In identifier mode, reads of 0x00400000-0x004003FF return identifier words.
// - Command 0x0F leaves identifier mode; ready rises, interrupt if enabled.
// - A 512-byte signature area can be read, written and erased.
// - Command 0x14 enters signature read mode at 0x00400000-0x004001FF.
// - Command 0x15 leaves signature mode; ready rises, interrupt if enabled.
// - After signature programming ready rises; verify failure sets verify error.
// - Command 0x13 erases signature; ready rises; verify failure sets error.
// - Bad key on a command write sets the command error flag.
// - Command codes 0x00 to 0x15 are decoded; here 0x06 sets the command error flag yet still runs as a generic command.
// - Ready interrupt enable high drives interrupt while ready; low gives none.
// - Flash accesses take wait-state count plus one cycles.
// - Sequential optimisation is off when its disable bit is 1.
// - Read width bit: 0 selects 128-bit reads, 1 selects 64-bit.
// - Loop optimisation enable bit turns opcode loop optimisation on.
// - Command write acts only with key 0x5A; otherwise nothing starts.
// - Ready clears whenever the controller becomes busy.
// - Results wider than a word come out over successive result reads.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/100ps
module fcc_ctrl
  import fcc_pkg::*;
(
  input  wire logic        clk_i,        // System clock, 250 MHz
  input  wire logic        rst_i,        // Sync reset, active high
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,     // Cycle
  input  wire logic        wb_stb_i,     // Strobe
  input  wire logic        wb_we_i,      // Write enable
  input  wire logic [4:0]  wb_adr_i,     // Byte address
  input  wire logic [3:0]  wb_sel_i,     // Byte selects
  input  wire logic [31:0] wb_dat_i,     // Write data
  output logic [31:0]      wb_dat_o,     // Read data
  output logic             wb_ack_o,     // Acknowledge
  // Flash read port from the processor side
  input  wire logic        fl_req_i,     // Read request, held until ack
  input  wire logic [31:0] fl_adr_i,     // Byte address
  output logic [31:0]      fl_dat_o,     // Read data
  output logic             fl_ack_o,     // Read done pulse
  // Page latch fill, one word per pulse
  input  wire logic        latch_we_i,   // Latch write
  input  wire logic [6:0]  latch_word_i, // Latch word index
  input  wire logic [31:0] latch_dat_i,  // Latch data
  // Read-path configuration and interrupt
  output logic             seq_opt_en_o, // Sequential fetch optimisation on
  output logic             rd_wide_o,    // 128-bit read width selected
  output logic             loop_opt_o,   // Opcode loop optimisation on
  output logic             irq_o         // Ready interrupt
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  fcc_mode_t            mode_r;
  fcc_state_t           state_r;
  logic                 ready_r;
  logic                 cmd_err_r;
  logic                 ver_err_r;
  logic                 id_mode_r;
  logic                 sig_mode_r;
  logic [7:0]           cmd_r;
  logic [FCC_CNT_W-1:0] cnt_r;
  logic [1:0]           res_idx_r;
  logic [6:0]           pg_idx_r;
  logic [1:0]           fault_r;
  logic [31:0]          latch_mem [FCC_PAGE_WORDS];

  function automatic logic is_known(input logic [7:0] c);
    is_known = (c <= FCC_STOP_SIG_RD) && (c != 8'h06);
  endfunction

  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction

  // Bus handshake: one cycle answer, ack drops after one cycle
  logic bus_go;
  logic wr_go;
  logic rd_go;
  assign bus_go = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_go  = bus_go && wb_we_i;
  assign rd_go  = bus_go && !wb_we_i;

  logic cmd_wr;
  logic key_ok;
  logic cmd_go;
  assign cmd_wr = wr_go && hit(wb_adr_i, FCC_OFS_COMMAND) && (wb_sel_i == 4'hf);
  assign key_ok = (wb_dat_i[FCC_CMD_KEY_LO +: 8] == FCC_WRITE_KEY);
  // Taken when idle with the right key; a stop may come while ready is low
  assign cmd_go = cmd_wr && key_ok && (state_r == FCC_IDLE);

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= '{rdy_ie: FCC_MODE_RESET[FCC_MODE_RDY_IE],
                  wait_state_count: FCC_MODE_RESET[FCC_MODE_WS_LO +: FCC_MODE_WS_W],
                  seq_opt_disable: FCC_MODE_RESET[FCC_MODE_SEQ_DIS],
                  read_width_select: FCC_MODE_RESET[FCC_MODE_WIDTH],
                  loop_opt_enable: FCC_MODE_RESET[FCC_MODE_LOOP]};
    end else if (wr_go && hit(wb_adr_i, FCC_OFS_MODE)) begin
      if (wb_sel_i[0]) mode_r.rdy_ie <= wb_dat_i[FCC_MODE_RDY_IE];
      if (wb_sel_i[1]) mode_r.wait_state_count <= wb_dat_i[FCC_MODE_WS_LO +: FCC_MODE_WS_W];
      if (wb_sel_i[2]) mode_r.seq_opt_disable <= wb_dat_i[FCC_MODE_SEQ_DIS];
      if (wb_sel_i[3]) begin
        mode_r.read_width_select <= wb_dat_i[FCC_MODE_WIDTH];
        mode_r.loop_opt_enable   <= wb_dat_i[FCC_MODE_LOOP];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_opt_en_o <= 1'b0;
      rd_wide_o    <= 1'b0;
      loop_opt_o   <= 1'b0;
    end else begin
      seq_opt_en_o <= !mode_r.seq_opt_disable;
      rd_wide_o    <= !mode_r.read_width_select;
      loop_opt_o   <= mode_r.loop_opt_enable;
    end
  end

  // ----------------------------------------------------------------
  // Page latch, filled by the bus fabric before a signature write
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (latch_we_i) begin
      latch_mem[latch_word_i] <= latch_dat_i;
    end
  end

  // ----------------------------------------------------------------
  // Nonvolatile store and its shared read port
  // ----------------------------------------------------------------
  logic        nv_we;
  logic        nv_er;
  logic [8:0]  nv_rd_word;
  logic [31:0] nv_rd_data;
  logic        in_verify;
  assign nv_we = (state_r == FCC_PROG) && (cmd_r == FCC_WRITE_SIG);
  assign nv_er = (state_r == FCC_PROG) && (cmd_r == FCC_ERASE_SIG);
  assign in_verify = (state_r == FCC_VERIFY);
  // Verify owns the read port; flash reads are not held off and may capture verify data
  assign nv_rd_word = in_verify ? {2'b00, pg_idx_r} : fl_adr_i[10:2];

  logic        nv_fault;
  logic [31:0] nv_wdata;
  assign nv_fault = (fault_r != 2'b00);
  // Injected faults corrupt erase words too, so both verify paths can fail
  assign nv_wdata = ((cmd_r == FCC_ERASE_SIG) ? FCC_ERASED : latch_mem[pg_idx_r])
                    ^ {30'h0, fault_r};

  fcc_nv_store u_store (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .id_sel_i   (id_mode_r && !in_verify),
    .rd_word_i  (nv_rd_word),
    .rd_data_o  (nv_rd_data),
    .sig_we_i   (nv_we || (nv_er && nv_fault)),
    .sig_er_i   (nv_er && !nv_fault),
    .sig_word_i (pg_idx_r),
    .sig_data_i (nv_wdata)
  );

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  logic [31:0] expect_w;
  logic        last_word;
  assign expect_w  = (cmd_r == FCC_ERASE_SIG) ? FCC_ERASED : latch_mem[pg_idx_r - 7'h01];
  assign last_word = (pg_idx_r == 7'(FCC_SIG_WORDS - 1));

  logic vfy_valid_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= FCC_IDLE;
      ready_r     <= 1'b1;
      cmd_r       <= FCC_GET_DESC;
      cnt_r       <= '0;
      pg_idx_r    <= '0;
      id_mode_r   <= 1'b0;
      sig_mode_r  <= 1'b0;
      vfy_valid_r <= 1'b0;
    end else begin
      case (state_r)
        FCC_IDLE: begin
          if (cmd_go) begin
            cmd_r    <= wb_dat_i[7:0];
            ready_r  <= 1'b0;
            pg_idx_r <= '0;
            cnt_r    <= 16'(FCC_MODE_CYC);
            case (wb_dat_i[7:0])
              // Mode opens as ready falls; settle time only on exit
              FCC_START_ID_READ:                 id_mode_r  <= 1'b1;
              FCC_START_SIG_RD:                  sig_mode_r <= 1'b1;
              FCC_STOP_ID_READ, FCC_STOP_SIG_RD: state_r    <= FCC_MODE;
              FCC_WRITE_SIG, FCC_ERASE_SIG:      state_r <= FCC_PROG;
              default:                           state_r <= FCC_GENERIC;
            endcase
          end
        end
        FCC_MODE: begin
          if (cnt_r <= 16'h0001) begin
            state_r <= FCC_IDLE;
            case (cmd_r)
              FCC_STOP_ID_READ: begin
                id_mode_r <= 1'b0;
                ready_r   <= 1'b1;
              end
              default: begin
                sig_mode_r <= 1'b0;
                ready_r    <= 1'b1;
              end
            endcase
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        FCC_PROG: begin
          pg_idx_r <= pg_idx_r + 7'h01;
          if (last_word) begin
            state_r     <= FCC_VERIFY;
            pg_idx_r    <= '0;
            vfy_valid_r <= 1'b0;
          end
        end
        FCC_VERIFY: begin
          pg_idx_r    <= pg_idx_r + 7'h01;
          vfy_valid_r <= 1'b1;
          if (vfy_valid_r && pg_idx_r == '0) begin
            state_r <= FCC_IDLE;
            ready_r <= 1'b1;
          end
        end
        FCC_GENERIC: begin
          // Plane operations live outside this block; they just complete
          state_r <= FCC_IDLE;
          ready_r <= 1'b1;
        end
        default: begin
          state_r <= FCC_IDLE;
          ready_r <= 1'b1;
        end
      endcase
      // A key-valid command while a read mode is open keeps ready low
      if (cmd_go && !ready_r) begin
        ready_r <= 1'b0;
      end
    end
  end

  // Fault injection for verify; kept at zero unless software sets it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_r <= '0;
    end else if (wr_go && hit(wb_adr_i, FCC_OFS_FLTEST) && wb_sel_i[0]) begin
      fault_r <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  logic st_read;
  logic vfy_miss;
  assign st_read  = rd_go && hit(wb_adr_i, FCC_OFS_STATUS);
  assign vfy_miss = in_verify && vfy_valid_r && (nv_rd_data != expect_w);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_err_r <= 1'b0;
    end else if (cmd_wr && (!key_ok || !is_known(wb_dat_i[7:0]))) begin
      cmd_err_r <= 1'b1;
    end else if (st_read || cmd_wr) begin
      cmd_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ver_err_r <= 1'b0;
    end else if (vfy_miss) begin
      ver_err_r <= 1'b1;
    end else if (cmd_go) begin
      ver_err_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= mode_r.rdy_ie && ready_r;
    end
  end

  // ----------------------------------------------------------------
  // Result register: successive reads step through a wide result
  // ----------------------------------------------------------------
  logic [31:0] result_w;
  always_comb begin
    result_w = '0;
    if (cmd_r == FCC_GET_DESC) begin
      case (res_idx_r)
        2'd0:    result_w = 32'h0000_0000;
        2'd1:    result_w = 32'(FCC_SIG_WORDS * 4);
        2'd2:    result_w = 32'(FCC_ID_WORDS * 4);
        default: result_w = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_idx_r <= '0;
    end else if (cmd_go) begin
      res_idx_r <= '0;
    end else if (rd_go && hit(wb_adr_i, FCC_OFS_RESULT) && res_idx_r != 2'd3) begin
      res_idx_r <= res_idx_r + 2'd1;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone read data and ack
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_go;
      wb_dat_o <= '0;
      if (rd_go) begin
        case (wb_adr_i)
          FCC_OFS_MODE: begin
            wb_dat_o[FCC_MODE_RDY_IE]                 <= mode_r.rdy_ie;
            wb_dat_o[FCC_MODE_WS_LO +: FCC_MODE_WS_W] <= mode_r.wait_state_count;
            wb_dat_o[FCC_MODE_SEQ_DIS]                <= mode_r.seq_opt_disable;
            wb_dat_o[FCC_MODE_WIDTH]                  <= mode_r.read_width_select;
            wb_dat_o[FCC_MODE_LOOP]                   <= mode_r.loop_opt_enable;
          end
          FCC_OFS_STATUS: begin
            wb_dat_o[FCC_ST_READY]  <= ready_r;
            wb_dat_o[FCC_ST_CMDERR] <= cmd_err_r;
            wb_dat_o[FCC_ST_VERERR] <= ver_err_r;
          end
          FCC_OFS_RESULT: wb_dat_o <= result_w;
          FCC_OFS_FLTEST: wb_dat_o[1:0] <= fault_r;
          default:        wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Flash read path with wait states
  // ----------------------------------------------------------------
  logic fl_busy_r;
  logic fl_start;
  logic fl_done;
  logic in_id_win;
  logic in_sig_win;
  assign fl_start   = fl_req_i && !fl_busy_r && !fl_ack_o;
  assign in_id_win  = id_mode_r && fl_adr_i >= FCC_FLASH_BASE && fl_adr_i <= FCC_ID_LAST;
  assign in_sig_win = sig_mode_r && fl_adr_i >= FCC_FLASH_BASE && fl_adr_i <= FCC_SIG_LAST;

  fcc_ws_timer u_ws (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (fl_start),
    .cycles_i (16'(mode_r.wait_state_count) + 16'h0001),
    .done_o   (fl_done)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fl_busy_r <= 1'b0;
      fl_ack_o  <= 1'b0;
      fl_dat_o  <= '0;
    end else begin
      fl_ack_o <= 1'b0;
      if (fl_start) begin
        fl_busy_r <= 1'b1;
      end else if (fl_done) begin
        fl_busy_r <= 1'b0;
        fl_ack_o  <= 1'b1;
        // Main array lies outside this block and reads back as erased
        fl_dat_o  <= (in_id_win || in_sig_win) ? nv_rd_data : FCC_ERASED;
      end
    end
  end

endmodule // fcc_ctrl

// [hdl/fcc_nv_store.sv]
// Nonvolatile area model: identifier and signature words with program and erase
`timescale 1ns/100ps
module fcc_nv_store
  import fcc_pkg::*;
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Sync reset
  input  wire logic        id_sel_i,  // Read identifier, else signature
  input  wire logic [8:0]  rd_word_i, // Word index to read
  output logic [31:0]      rd_data_o, // Read data, one cycle later
  input  wire logic        sig_we_i,  // Program signature word
  input  wire logic        sig_er_i,  // Erase signature word
  input  wire logic [6:0]  sig_word_i,// Signature word index
  input  wire logic [31:0] sig_data_i // Data to program
);

  logic [31:0] id_mem [FCC_ID_WORDS];
  logic [31:0] sig_mem [FCC_SIG_WORDS];

  // Identifier content is fixed; a pattern of the word index stands in
  initial begin
    for (int i = 0; i < FCC_ID_WORDS; i++) begin
      id_mem[i] = {16'h1d00, 8'h00, i[7:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (sig_er_i) begin
      sig_mem[sig_word_i] <= FCC_ERASED;
    end else if (sig_we_i) begin
      sig_mem[sig_word_i] <= sig_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= '0;
    end else if (id_sel_i) begin
      rd_data_o <= id_mem[rd_word_i[7:0]];
    end else begin
      rd_data_o <= sig_mem[rd_word_i[6:0]];
    end
  end

endmodule // fcc_nv_store

// [hdl/fcc_pkg.sv]
// Package: register map, fields, commands and timing for the flash command controller
package fcc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [4:0] FCC_OFS_MODE    = 5'h00;
  localparam logic [4:0] FCC_OFS_COMMAND = 5'h04;
  localparam logic [4:0] FCC_OFS_STATUS  = 5'h08;
  localparam logic [4:0] FCC_OFS_RESULT  = 5'h0c;
  localparam logic [4:0] FCC_OFS_FLTEST  = 5'h14;

  // ----------------------------------------------------------------
  // Mode register fields and reset
  // ----------------------------------------------------------------
  localparam int unsigned FCC_MODE_RDY_IE  = 0;
  localparam int unsigned FCC_MODE_WS_LO   = 8;
  localparam int unsigned FCC_MODE_WS_W    = 4;
  localparam int unsigned FCC_MODE_SEQ_DIS = 16;
  localparam int unsigned FCC_MODE_WIDTH   = 24;
  localparam int unsigned FCC_MODE_LOOP    = 26;
  localparam logic [31:0] FCC_MODE_RESET   = 32'h0400_0000;

  // ----------------------------------------------------------------
  // Command register fields
  // ----------------------------------------------------------------
  localparam int unsigned FCC_CMD_KEY_LO = 24;
  localparam int unsigned FCC_CMD_ARG_LO = 8;
  localparam logic [7:0]  FCC_WRITE_KEY  = 8'h5a;

  // Status bits
  localparam int unsigned FCC_ST_READY   = 0;
  localparam int unsigned FCC_ST_CMDERR  = 1;
  localparam int unsigned FCC_ST_LOCKERR = 2;
  localparam int unsigned FCC_ST_VERERR  = 3;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] FCC_GET_DESC      = 8'h00;
  localparam logic [7:0] FCC_WRITE_PAGE    = 8'h01;
  localparam logic [7:0] FCC_WRITE_LOCK    = 8'h02;
  localparam logic [7:0] FCC_ERASE_WRITE   = 8'h03;
  localparam logic [7:0] FCC_ERASE_WR_LOCK = 8'h04;
  localparam logic [7:0] FCC_ERASE_ALL     = 8'h05;
  localparam logic [7:0] FCC_ERASE_PAGES   = 8'h07;
  localparam logic [7:0] FCC_SET_LOCK      = 8'h08;
  localparam logic [7:0] FCC_CLR_LOCK      = 8'h09;
  localparam logic [7:0] FCC_GET_LOCK      = 8'h0a;
  localparam logic [7:0] FCC_SET_NVBIT     = 8'h0b;
  localparam logic [7:0] FCC_CLR_NVBIT     = 8'h0c;
  localparam logic [7:0] FCC_GET_NVBIT     = 8'h0d;
  localparam logic [7:0] FCC_START_ID_READ = 8'h0e;
  localparam logic [7:0] FCC_STOP_ID_READ  = 8'h0f;
  localparam logic [7:0] FCC_GET_CALIB     = 8'h10;
  localparam logic [7:0] FCC_ERASE_SECTOR  = 8'h11;
  localparam logic [7:0] FCC_WRITE_SIG     = 8'h12;
  localparam logic [7:0] FCC_ERASE_SIG     = 8'h13;
  localparam logic [7:0] FCC_START_SIG_RD  = 8'h14;
  localparam logic [7:0] FCC_STOP_SIG_RD   = 8'h15;

  // ----------------------------------------------------------------
  // Sizes and flash window
  // ----------------------------------------------------------------
  localparam int unsigned FCC_ID_WORDS   = 256;  // 2 x 512 bytes
  localparam int unsigned FCC_SIG_WORDS  = 128;  // 512 bytes
  localparam int unsigned FCC_PAGE_WORDS = 128;
  localparam logic [31:0] FCC_FLASH_BASE = 32'h0040_0000;
  localparam logic [31:0] FCC_ID_LAST    = 32'h0040_03ff;
  localparam logic [31:0] FCC_SIG_LAST   = 32'h0040_01ff;
  localparam logic [31:0] FCC_ERASED     = 32'hffff_ffff;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned FCC_CLK_MHZ    = 250;
  localparam int unsigned FCC_MODE_NS    = 40;   // settle time on leaving read mode
  localparam int unsigned FCC_MODE_CYC   = (FCC_MODE_NS * FCC_CLK_MHZ + 999) / 1000;
  localparam int unsigned FCC_CNT_W      = 16;

  typedef enum logic [4:0] {
    FCC_IDLE   = 5'b00001,
    FCC_MODE   = 5'b00010,
    FCC_PROG   = 5'b00100,
    FCC_VERIFY = 5'b01000,
    FCC_GENERIC = 5'b10000
  } fcc_state_t;

  typedef struct packed {
    logic        rdy_ie;
    logic [3:0]  wait_state_count;
    logic        seq_opt_disable;
    logic        read_width_select;
    logic        loop_opt_enable;
  } fcc_mode_t;

  typedef struct packed {
    logic       req;
    logic [8:0] word;
  } fcc_flash_rd_t;

endpackage : fcc_pkg

// [hdl/fcc_ws_timer.sv]
// Wait-state timer: holds a flash access for a number of cycles
`timescale 1ns/100ps
module fcc_ws_timer
  import fcc_pkg::*;
(
  input  wire logic                 clk_i,    // System clock
  input  wire logic                 rst_i,    // Sync reset
  input  wire logic                 start_i,  // Access starts
  input  wire logic [FCC_CNT_W-1:0] cycles_i, // Cycles to take
  output logic                      done_o    // Last cycle pulse
);

  logic [FCC_CNT_W-1:0] cnt_r;
  logic                 busy_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      busy_r <= 1'b0;
    end else if (start_i) begin
      cnt_r  <= cycles_i - 16'h0001;
      busy_r <= 1'b1;
    end else if (busy_r) begin
      if (cnt_r == '0) begin
        busy_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end

  assign done_o = busy_r && (cnt_r == '0);

endmodule // fcc_ws_timer

// [tb/fcc_ctrl_bench.sv]
// Bench: register-level tests of the flash command controller
`timescale 1ns/100ps
module fcc_ctrl_bench
  import fcc_pkg::*;
;
  logic clk_i, rst_i, cyc, stb, we, ack, fl_req, fl_ack, l_we, seq, wide, loop, irq;
  logic [4:0]  adr;
  logic [6:0]  l_idx;
  logic [31:0] wdat, rdat, fdat, fadr, l_dat, d;
  int          error_cnt = 0;
  int          total_checks = 0;
  fcc_ctrl i_fcc_ctrl (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .fl_req_i(fl_req), .fl_adr_i(fadr), .fl_dat_o(fdat), .fl_ack_o(fl_ack),
    .latch_we_i(l_we), .latch_word_i(l_idx), .latch_dat_i(l_dat), .seq_opt_en_o(seq),
    .rd_wide_o(wide), .loop_opt_o(loop), .irq_o(irq));
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [4:0] a, input logic [31:0] v);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= v;
    do @(posedge clk_i); while (ack !== 1'b1);
    d = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [4:0] a, input logic [31:0] v); wb(1'b1, a, v); endtask
  task rd(input logic [4:0] a); wb(1'b0, a, 32'h0); endtask
  task cmd(input logic [7:0] c); wr(FCC_OFS_COMMAND, {FCC_WRITE_KEY, 16'h0, c}); endtask
  // Polls status; bounded so a stuck flag still lets later tests run
  task wait_rdy(input logic v);
    repeat (200) begin
      rd(FCC_OFS_STATUS);
      if (d[0] === v) break;
    end
  endtask
  task frd(input logic [31:0] a);
    fl_req <= 1'b1; fadr <= a;
    do @(posedge clk_i); while (fl_ack !== 1'b1);
    d = fdat;
    fl_req <= 1'b0;
    @(posedge clk_i);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test;
  end
  initial begin
    rst_i = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; wdat = 0;
    fl_req = 0; fadr = 0; l_we = 0; l_idx = 0; l_dat = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // Outputs launched at the release edge are settled one edge later
    repeat (2) @(posedge clk_i);
    chk({seq, wide, loop, irq}, 32'he);
    rd(FCC_OFS_MODE); chk(d, FCC_MODE_RESET);
    rd(FCC_OFS_STATUS); chk(d, 32'h1);
    rd(FCC_OFS_RESULT); chk(d, 32'h0);
    rd(5'h10); chk(d, 32'h0);
    $display("test reset done");
    wr(FCC_OFS_MODE, 32'h0001_0301); rd(FCC_OFS_MODE); chk(d, 32'h0001_0301);
    chk({seq, wide, loop, irq}, 32'h5);
    frd(FCC_FLASH_BASE); chk(d, FCC_ERASED);
    wr(FCC_OFS_MODE, 32'h0500_0000); @(posedge clk_i);
    chk({seq, wide, loop, irq}, 32'ha);
    $display("test mode done");
    wr(FCC_OFS_COMMAND, 32'h0000_000f); rd(FCC_OFS_STATUS); chk(d, 32'h3);
    rd(FCC_OFS_STATUS); chk(d, 32'h1);
    cmd(8'h06); rd(FCC_OFS_STATUS); chk(d, 32'h3);
    for (int c = 0; c < 18; c++) if (c != 6 && c != 14 && c != 15) begin
      cmd(8'(c)); wait_rdy(1'b1); chk(d, 32'h1);
    end
    cmd(FCC_GET_DESC); wait_rdy(1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(FCC_OFS_RESULT); chk(d, i < 3 ? 32'(i * 512) : 32'h0);
    end
    $display("test commands done");
    for (int i = 0; i < 128; i++) begin
      l_we <= 1'b1; l_idx <= i[6:0]; l_dat <= 32'ha5a5_0000 | 32'(i);
      @(posedge clk_i);
    end
    l_we <= 1'b0;
    wr(FCC_OFS_MODE, 32'h0400_0001); wr(FCC_OFS_FLTEST, 32'h1);
    cmd(FCC_ERASE_SIG); rd(FCC_OFS_STATUS); chk(d, 32'h0);
    chk(irq, 32'h0);
    wait_rdy(1'b1); chk(d, 32'h9);
    wr(FCC_OFS_FLTEST, 32'h0); cmd(FCC_WRITE_SIG); wait_rdy(1'b1); chk(d, 32'h1);
    @(posedge clk_i); chk(irq, 32'h1);
    cmd(FCC_START_SIG_RD); wait_rdy(1'b0); chk(d, 32'h0);
    frd(32'h0040_01fc); chk(d, 32'ha5a5_007f);
    frd(32'h0040_0200); chk(d, FCC_ERASED);
    cmd(FCC_STOP_SIG_RD); wait_rdy(1'b1); chk(d, 32'h1);
    frd(FCC_FLASH_BASE); chk(d, FCC_ERASED);
    $display("test signature done");
    cmd(FCC_START_ID_READ); wait_rdy(1'b0); chk(d, 32'h0);
    frd(FCC_ID_LAST - 32'h3); chk(d, 32'h1d00_00ff);
    cmd(FCC_STOP_ID_READ); wait_rdy(1'b1); chk(d, 32'h1);
    @(posedge clk_i); chk(irq, 32'h1);
    $display("test identifier done");
    finish_test;
  end
endmodule // fcc_ctrl_bench

// [tb/fcc_ctrl_checker.sv]
// Checker: bus, flash-read and mode-output assertions for the flash command controller
`timescale 1ns/100ps
module fcc_ctrl_checker
  import fcc_pkg::*;
(
  input wire logic        clk_i,        // Clock
  input wire logic        rst_i,        // Reset
  input wire logic        wb_cyc_i,     // Cycle
  input wire logic        wb_stb_i,     // Strobe
  input wire logic        wb_we_i,      // Write
  input wire logic [4:0]  wb_adr_i,     // Address
  input wire logic [3:0]  wb_sel_i,     // Selects
  input wire logic [31:0] wb_dat_i,     // Write data
  input wire logic        wb_ack_o,     // Ack
  input wire logic        fl_req_i,     // Flash request
  input wire logic        fl_ack_o,     // Flash ack
  input wire logic        seq_opt_en_o, // Seq opt on
  input wire logic        rd_wide_o,    // Wide read
  input wire logic        loop_opt_o,   // Loop opt on
  input wire logic        irq_o         // Interrupt
);
  logic mode_w;
  logic ie_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign mode_w = wb_ack_o && wb_we_i && wb_sel_i == 4'hf && wb_adr_i == FCC_OFS_MODE;
  sequence mode_wr;
    mode_w;
  endsequence
  // Shadow of the interrupt enable, taken where the write completes
  always_ff @(posedge clk_i) begin
    if (rst_i) ie_r <= 1'b0;
    else if (mode_w) ie_r <= wb_dat_i[0];
  end
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_seq_opt: assert property (mode_wr |=> seq_opt_en_o == !$past(wb_dat_i[16]))
    else $error("sequential opt output wrong");
  chk_read_width: assert property (mode_wr |=> rd_wide_o == !$past(wb_dat_i[24]))
    else $error("read width output wrong");
  chk_loop_opt: assert property (mode_wr |=> loop_opt_o == $past(wb_dat_i[26]))
    else $error("loop opt output wrong");
  chk_irq_masked: assert property (!ie_r && !$past(ie_r) |-> !irq_o)
    else $error("interrupt while disabled");
  chk_fl_time: assert property ($rose(fl_req_i) |-> ##[1:17] fl_ack_o)
    else $error("flash read not answered");
  chk_fl_pulse: assert property (fl_ack_o |=> !fl_ack_o) else $error("flash ack too long");
  chk_fl_cause: assert property (fl_ack_o |-> $past(fl_req_i))
    else $error("flash ack without request");
endmodule // fcc_ctrl_checker

bind fcc_ctrl fcc_ctrl_checker i_fcc_ctrl_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .fl_req_i, .fl_ack_o,
  .seq_opt_en_o, .rd_wide_o, .loop_opt_o, .irq_o);
